// ---- pkg/pm_cfg_consts.svh ----
// Offsets, field positions and reset values of the power management config bank
`ifndef PM_CFG_CONSTS_SVH
`define PM_CFG_CONSTS_SVH

`define OFS_FIRST_CAP_PTR 8'h34
`define OFS_POWER_CAP_HDR 8'h80
`define OFS_POWER_CTRL_STS 8'h84
`define OFS_IDLE_CAP_REC 8'h90
`define OFS_LATENCY_PTR 8'h98
`define OFS_IDLE_LOC_PTR 8'h9C
`define OFS_PG_CONFIG 8'hA0
`define OFS_SCRATCH_0 8'hB0
`define OFS_SCRATCH_1 8'hB4
`define OFS_SCRATCH_2 8'hB8
`define OFS_SCRATCH_3 8'hBC
`define OFS_INPUT_WORD 8'hC0

`define VAL_FIRST_CAP_PTR 32'h0000_0080
`define VAL_POWER_CAP_HDR 32'h0003_9001
`define VAL_IDLE_CAP_REC 32'hF014_0009
`define VAL_LATENCY_PTR 32'h0000_2101
`define VAL_IDLE_LOC_PTR 32'h0000_24C1
`define VAL_ZERO_WORD 32'h0000_0000

`define VAL_WAKE_SUPPORT 5'h00
`define VAL_LAT_SCALE 3'h2
`define VAL_LAT_VALUE 10'h000

`define BIT_WAKE_FLAG 15
`define BIT_WAKE_ENABLE 8
`define BIT_NO_SOFT_RESET 3
`define POS_WAKE_SUPPORT 27
`define BIT_SLEEP_ALLOW 19
`define BIT_POWER_GATE 18
`define BIT_IDLE_GATE 17
`define BIT_CTRL_REQUEST 16
`define POS_LAT_SCALE 10
`define POS_LAT_VALUE 0

`endif

// ---- pkg/pm_cfg_pkg.sv ----
// Types shared by the power management config bank and its users
package pm_cfg_pkg;

  typedef enum logic [1:0] {
    PWR_D0 = 2'b00,
    PWR_D3HOT = 2'b11
  } power_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cfg_rsp_type;

endpackage

// ---- rtl/pm_cfg_regs.sv ----
// Power management and device idle configuration register bank
// Function
// - Power state field reports and accepts D0/D3hot
// - Writes of 01b or 10b are discarded
// - Interrupts blocked while in D3hot
// - No soft reset bit reads one
// - Sticky wake message enable gates wake messages
// - Sticky wake flag, set by hardware, write-one-clears
// - Wake support field reads zero, read-only
// - Capability header reads 39001h
// - Vendor idle capability reads F0140009h, chain ends
// - Latency pointer reads 2101h, read-only
// - Idle pointer reads 24C1h, read-only
// - Power gate allow clear means never gate
// - Idle gate allow gates when idle in D3hot
// - Controller request allow gates when idle
// - Sticky latency scale and value fields
// - Four read-write scratch words at B0h-BCh
// - Read-only input word at C0h
// - First capability pointer at 34h reads 80h
`include "pm_cfg_consts.svh"

module pm_cfg_regs (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_n, // Power-on reset, returns everything to its reset value
  input wire logic func_rst_n, // Synchronous function reset, spares sticky bits
  input wire pm_cfg_pkg::cfg_req_type cfg_req, // Configuration access request
  output pm_cfg_pkg::cfg_rsp_type cfg_rsp, // Configuration access answer
  input wire logic wake_event, // Wake event pulse from the function
  output logic wake_message, // Wake message pulse to the platform
  input wire logic func_intr, // Interrupt request from the function
  output logic intr_out, // Interrupt after power state gating
  input wire logic func_idle, // Function reports it is idle
  input wire logic dev_idle, // Device idle indication set by driver
  output logic pg_request, // Power gate request to the controller
  output logic sleep_allow, // Sleep enable field
  output pm_cfg_pkg::power_state_type power_state, // Present power state
  input wire logic [31:0] gp_input // General purpose input pins
);
  import pm_cfg_pkg::*;

  logic wake_flag;
  logic wake_enable;
  logic sleep_en;
  logic power_gate_allow;
  logic idle_gate_allow;
  logic controller_gate_request_allow;
  logic [2:0] latency_scale_field;
  logic [9:0] latency_value_field;
  logic latency_locked;
  logic [31:0] scratch_word [4];
  logic [31:0] input_word;
  logic [31:0] next_rdata;

  logic wr_access;
  logic rd_access;
  logic [31:0] wmask;

  function automatic logic [31:0] byte_mask(input logic [3:0] be);
    byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] merge_word(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [31:0] mask);
    merge_word = (old_val & ~mask) | (new_val & mask);
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction

  assign wr_access = cfg_req.valid && cfg_req.write;
  assign rd_access = cfg_req.valid && !cfg_req.write;
  assign wmask = byte_mask(cfg_req.byte_en);

  // Power state is not sticky; leaving D3hot keeps all other state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_state <= PWR_D0;
    end else if (!func_rst_n) begin
      power_state <= PWR_D0;
    end else if (wr_access && hit(cfg_req.addr, `OFS_POWER_CTRL_STS) && cfg_req.byte_en[0]) begin
      if (cfg_req.wdata[1:0] == PWR_D0) begin
        power_state <= PWR_D0;
      end else if (cfg_req.wdata[1:0] == PWR_D3HOT) begin
        power_state <= PWR_D3HOT;
      end
      // Reserved encodings fall through, state unchanged
    end
  end

  // Sticky wake enable and flag survive the function reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_enable <= 1'b0;
    end else if (wr_access && hit(cfg_req.addr, `OFS_POWER_CTRL_STS) && cfg_req.byte_en[1]) begin
      wake_enable <= cfg_req.wdata[`BIT_WAKE_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_flag <= 1'b0;
    end else if (wake_event) begin
      // Set beats a simultaneous clear so no event is lost
      wake_flag <= 1'b1;
    end else if (wr_access && hit(cfg_req.addr, `OFS_POWER_CTRL_STS)
                 && cfg_req.byte_en[1] && cfg_req.wdata[`BIT_WAKE_FLAG]) begin
      wake_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_message <= 1'b0;
    end else begin
      wake_message <= wake_event && wake_enable;
    end
  end

  // Sticky power gating enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_en <= 1'b1;
      power_gate_allow <= 1'b1;
      idle_gate_allow <= 1'b1;
      controller_gate_request_allow <= 1'b1;
    end else if (wr_access && hit(cfg_req.addr, `OFS_PG_CONFIG) && cfg_req.byte_en[2]) begin
      sleep_en <= cfg_req.wdata[`BIT_SLEEP_ALLOW];
      power_gate_allow <= cfg_req.wdata[`BIT_POWER_GATE];
      idle_gate_allow <= cfg_req.wdata[`BIT_IDLE_GATE];
      controller_gate_request_allow <= cfg_req.wdata[`BIT_CTRL_REQUEST];
    end
  end

  // Latency fields: written once by firmware, then held until power loss
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latency_scale_field <= `VAL_LAT_SCALE;
      latency_value_field <= `VAL_LAT_VALUE;
      latency_locked <= 1'b0;
    end else if (wr_access && hit(cfg_req.addr, `OFS_PG_CONFIG)
                 && (cfg_req.byte_en[1:0] != 2'h0) && !latency_locked) begin
      latency_locked <= 1'b1;
      if (cfg_req.byte_en[0]) begin
        latency_value_field[7:0] <= cfg_req.wdata[7:0];
      end
      if (cfg_req.byte_en[1]) begin
        latency_value_field[9:8] <= cfg_req.wdata[9:8];
        latency_scale_field <= cfg_req.wdata[12:10];
      end
    end
  end

  // Scratch words are plain storage, cleared by either reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        scratch_word[i] <= `VAL_ZERO_WORD;
      end
    end else if (!func_rst_n) begin
      for (int i = 0; i < 4; i++) begin
        scratch_word[i] <= `VAL_ZERO_WORD;
      end
    end else if (wr_access) begin
      if (hit(cfg_req.addr, `OFS_SCRATCH_0)) begin
        scratch_word[0] <= merge_word(scratch_word[0], cfg_req.wdata, wmask);
      end
      if (hit(cfg_req.addr, `OFS_SCRATCH_1)) begin
        scratch_word[1] <= merge_word(scratch_word[1], cfg_req.wdata, wmask);
      end
      if (hit(cfg_req.addr, `OFS_SCRATCH_2)) begin
        scratch_word[2] <= merge_word(scratch_word[2], cfg_req.wdata, wmask);
      end
      if (hit(cfg_req.addr, `OFS_SCRATCH_3)) begin
        scratch_word[3] <= merge_word(scratch_word[3], cfg_req.wdata, wmask);
      end
    end
  end

  // Input word follows the pins; bus writes never reach it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_word <= `VAL_ZERO_WORD;
    end else begin
      input_word <= gp_input;
    end
  end

  // Read mux; anything not decoded reads zero
  always_comb begin
    next_rdata = `VAL_ZERO_WORD;
    // Compare dword-aligned offsets; low address bits never select a byte lane here
    unique case ({cfg_req.addr[7:2], 2'b00})
      `OFS_FIRST_CAP_PTR: next_rdata = `VAL_FIRST_CAP_PTR;
      `OFS_POWER_CAP_HDR: begin
        next_rdata = `VAL_POWER_CAP_HDR;
        next_rdata[31:27] = `VAL_WAKE_SUPPORT;
      end
      `OFS_POWER_CTRL_STS: begin
        next_rdata[1:0] = power_state;
        next_rdata[`BIT_NO_SOFT_RESET] = 1'b1;
        next_rdata[`BIT_WAKE_ENABLE] = wake_enable;
        next_rdata[`BIT_WAKE_FLAG] = wake_flag;
      end
      `OFS_IDLE_CAP_REC: next_rdata = `VAL_IDLE_CAP_REC;
      `OFS_LATENCY_PTR: next_rdata = `VAL_LATENCY_PTR;
      `OFS_IDLE_LOC_PTR: next_rdata = `VAL_IDLE_LOC_PTR;
      `OFS_PG_CONFIG: begin
        next_rdata[`BIT_SLEEP_ALLOW] = sleep_en;
        next_rdata[`BIT_POWER_GATE] = power_gate_allow;
        next_rdata[`BIT_IDLE_GATE] = idle_gate_allow;
        next_rdata[`BIT_CTRL_REQUEST] = controller_gate_request_allow;
        next_rdata[12:10] = latency_scale_field;
        next_rdata[9:0] = latency_value_field;
      end
      `OFS_SCRATCH_0: next_rdata = scratch_word[0];
      `OFS_SCRATCH_1: next_rdata = scratch_word[1];
      `OFS_SCRATCH_2: next_rdata = scratch_word[2];
      `OFS_SCRATCH_3: next_rdata = scratch_word[3];
      `OFS_INPUT_WORD: next_rdata = input_word;
      default: next_rdata = `VAL_ZERO_WORD;
    endcase
  end

  // Every request is answered one cycle later; writes return zero data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.ack <= cfg_req.valid;
      cfg_rsp.rdata <= rd_access ? next_rdata : `VAL_ZERO_WORD;
    end
  end

  // Gating decisions are registered so the controller sees clean levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_request <= 1'b0;
      intr_out <= 1'b0;
    end else begin
      // Power gate allow is the master switch over the other sources
      pg_request <= power_gate_allow && func_idle
                    && (dev_idle
                        || (idle_gate_allow && power_state == PWR_D3HOT)
                        || controller_gate_request_allow);
      intr_out <= func_intr && (power_state != PWR_D3HOT);
    end
  end

  assign sleep_allow = sleep_en;

endmodule

// ---- tb/pm_func_model.sv ----
// Function-side model: random interrupt and idle levels, holdable input word
module pm_func_model (
  input wire logic clk, // Bench clock
  input wire logic hold, // Freeze the input word
  output logic func_intr, // Interrupt level
  output logic func_idle, // Function idle level
  output logic dev_idle, // Driver idle indication
  output logic [31:0] gp_input // Input word pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {func_intr, func_idle, dev_idle, gp_input} = '0;
  end
  // Levels wander every cycle so gating sees every combination
  always @(posedge clk) begin
    {func_intr, func_idle, dev_idle} <= 3'($urandom);
    if (!hold) gp_input <= $urandom;
  end
endmodule

// ---- tb/pm_cfg_regs_asserts.sv ----
// Port checker for the power management config bank
`include "pm_cfg_consts.svh"
module pm_cfg_regs_asserts (
  input wire logic clk, // Clock
  input wire logic rst_n, // Power-on reset
  input wire logic func_rst_n, // Function reset
  input wire pm_cfg_pkg::cfg_req_type cfg_req, // Request
  input wire pm_cfg_pkg::cfg_rsp_type cfg_rsp, // Answer
  input wire logic wake_event, // Wake event
  input wire logic wake_message, // Wake message
  input wire logic func_intr, // Function interrupt
  input wire logic intr_out, // Gated interrupt
  input wire logic func_idle, // Function idle
  input wire logic pg_request, // Gate request
  input wire pm_cfg_pkg::power_state_type power_state // Power state
);
  import pm_cfg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence req_s(logic w, logic [5:0] dw);
    cfg_req.valid && cfg_req.write == w && cfg_req.addr[7:2] == dw;
  endsequence
  sequence state_wr_s;
    req_s(1'b1, 6'h21) ##0 (cfg_req.byte_en[0] && func_rst_n);
  endsequence
  ack_timing_a: assert property (cfg_req.valid |=> cfg_rsp.ack)
    else $error("ack missing");
  ack_stray_a: assert property (!cfg_req.valid |=> !cfg_rsp.ack)
    else $error("stray ack");
  idle_rdata_a: assert property (!cfg_rsp.ack |-> cfg_rsp.rdata == '0)
    else $error("rdata without ack");
  cap_read_a: assert property (req_s(1'b0, 6'h20) |=> cfg_rsp.rdata == `VAL_POWER_CAP_HDR)
    else $error("capability header wrong");
  ptr_read_a: assert property (req_s(1'b0, 6'h0D) |=> cfg_rsp.rdata == `VAL_FIRST_CAP_PTR)
    else $error("first pointer wrong");
  state_set_a: assert property (state_wr_s ##0 cfg_req.wdata[1:0] == 2'b11
    |=> power_state == PWR_D3HOT) else $error("state not taken");
  state_keep_a: assert property (state_wr_s ##0 cfg_req.wdata[1:0] inside {2'b01, 2'b10}
    |=> $stable(power_state)) else $error("reserved state taken");
  func_rst_a: assert property (!func_rst_n |=> power_state == PWR_D0)
    else $error("function reset ignored");
  intr_block_a: assert property ($past(rst_n) |-> intr_out ==
    ($past(func_intr) && $past(power_state) != PWR_D3HOT)) else $error("interrupt gating wrong");
  wake_cause_a: assert property (wake_message |-> $past(wake_event))
    else $error("wake message without event");
  gate_idle_a: assert property (pg_request |-> $past(func_idle))
    else $error("gate request while busy");
endmodule
bind pm_cfg_regs pm_cfg_regs_asserts chk (.clk, .rst_n, .func_rst_n, .cfg_req, .cfg_rsp,
  .wake_event, .wake_message, .func_intr, .intr_out, .func_idle, .pg_request, .power_state);

// ---- tb/pm_cfg_regs_bench.sv ----
// Self-checking bench for the power management config bank
module pm_cfg_regs_bench;
  import pm_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, func_rst_n = 1, wake_event = 0, hold = 1;
  cfg_req_type cfg_req = '0;
  cfg_rsp_type cfg_rsp;
  logic wake_message, func_intr, intr_out, func_idle, dev_idle, pg_request, sleep_allow;
  power_state_type power_state;
  logic [31:0] gp_input, r, sw[4], q[$];
  logic [7:0] ra[12] = '{8'h34, 8'h80, 8'h90, 8'h98, 8'h9C, 8'hC0, 8'h40, 8'h84, 8'hA0,
    8'hB0, 8'hB8, 8'hBC};
  logic [31:0] rv[12] = '{32'h80, 32'h39001, 32'hF014_0009, 32'h2101, 32'h24C1, 32'h0,
    32'h0, 32'h8, 32'hF_0800, 32'h0, 32'h0, 32'h0};
  logic [1:0] pw[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  logic [31:0] pe[4] = '{32'h10B, 32'h10B, 32'h10B, 32'h108};
  int num_errors = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  pm_cfg_regs dut (.clk, .rst_n, .func_rst_n, .cfg_req, .cfg_rsp, .wake_event, .wake_message,
    .func_intr, .intr_out, .func_idle, .dev_idle, .pg_request, .sleep_allow, .power_state,
    .gp_input);
  pm_func_model fm (.clk, .hold, .func_intr, .func_idle, .dev_idle, .gp_input);
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One request per edge; writes answer with zero data
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
    @(posedge clk);
    cfg_req <= '{1'b1, w, a, 4'hF, d};
    q.push_back(w ? 32'h0 : e);
  endtask
  task automatic drain();
    @(posedge clk);
    cfg_req <= '0;
    for (int i = 0; i < 20 && q.size() != 0; i++) @(posedge clk);
    if (q.size() != 0) begin
      chk("answers outstanding", 32'(q.size()), 32'h0);
      give_verdict();
    end
  endtask
  // Negedge sampling keeps clear of the registered answer's update
  always @(negedge clk) if (cfg_rsp.ack) begin
    chk("rdata", cfg_rsp.rdata, (q.size() != 0) ? q.pop_front() : 32'hDEAD_0001);
  end
  initial begin
    r = $urandom(87565);
    foreach (sw[i]) sw[i] = $urandom;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 7; i++) acc(1, ra[i], 32'hFFFF_FFFF, 32'h0);
    foreach (ra[i]) acc(0, ra[i], 32'h0, rv[i]);
    for (int i = 0; i < 4; i++) acc(1, 8'hB0 + 8'(4 * i), sw[i], 32'h0);
    for (int i = 0; i < 4; i++) acc(0, 8'hB0 + 8'(4 * i), 32'h0, sw[i]);
    foreach (pw[i]) begin
      acc(1, 8'h84, 32'h100 | 32'(pw[i]), 32'h0);
      acc(0, 8'h84, 32'h0, pe[i]);
    end
    acc(0, 8'hB0, 32'h0, sw[0]);
    drain();
    @(posedge clk) wake_event <= 1;
    @(posedge clk) wake_event <= 0;
    @(negedge clk) chk("wake_message", 32'(wake_message), 32'h1);
    acc(0, 8'h84, 32'h0, 32'h8108);
    acc(1, 8'h84, 32'h103, 32'h0);
    acc(0, 8'h84, 32'h0, 32'h810B);
    acc(1, 8'h84, 32'h8103, 32'h0);
    acc(0, 8'h84, 32'h0, 32'h10B);
    drain();
    @(posedge clk) func_rst_n <= 0;
    @(posedge clk) func_rst_n <= 1;
    acc(0, 8'h84, 32'h0, 32'h108);
    acc(0, 8'hB4, 32'h0, 32'h0);
    acc(1, 8'hA0, 32'h1555, 32'h0);
    acc(0, 8'hA0, 32'h0, 32'h1555);
    acc(1, 8'hA0, 32'hF_0AAA, 32'h0);
    acc(0, 8'hA0, 32'h0, 32'hF_1555);
    drain();
    chk("sleep_allow", 32'(sleep_allow), 32'h1);
    @(posedge clk) hold <= 0;
    @(posedge clk) hold <= 1;
    repeat (3) @(posedge clk);
    acc(0, 8'hC0, 32'h0, gp_input);
    drain();
    @(posedge clk) rst_n <= 0;
    @(posedge clk) rst_n <= 1;
    acc(0, 8'hA0, 32'h0, 32'hF_0800);
    drain();
    give_verdict();
  end
endmodule
